// *** rtl/dewc_core.sv ***
// Data EEPROM write control: unlock, self-timed write, done flag and wake
`timescale 1ns/1ps
// Function
// [R1] Write keeps running while the core sleeps; sleep is never blocked.
// [R2] Write completion sets the done flag, which wakes the core.
// [R3] Wake needs done enable and group enable; other enabled sources also wake.
// [R4] Initiate bit reads set during a write and self-clears at completion.
// [R5] Done flag set wins over a software flag update in the same cycle.
// [R6] Software avoids touching the flag register during a write.
// [R7] Software may use a timeout above 8 ms, then check initiate and error.
// [R8] An error flag is readable alongside the initiate bit.
// [R9] Software keeps its own active flag amid other periodic interrupts.
// [R10] Start only with write enable and 55h then AAh just before.
// [R11] Program data at address; both held stable during the write.
module dewc_core
    import dewc_pkg::*;
#(
    parameter int WRITE_CYC = WRITE_CYCLES,
    parameter int AW = ADDR_W
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire dewc_sw_s sw_in,
    input wire logic [AW-1:0] eeprom_address_reg_in,
    input wire logic [DATA_W-1:0] eeprom_data_reg_in,
    input wire logic write_done_irq_enable_in,
    input wire logic peripheral_group_enable_in,
    input wire logic other_irq_pending_in,
    input wire logic core_asleep_in,
    input wire logic brownout_in,
    output logic [7:0] eeprom_control_reg_out,
    output logic write_done_flag_out,
    output logic write_error_flag_out,
    output logic write_enable_bit_out,
    output logic wake_out,
    output logic nvm_we_out,
    output logic [AW-1:0] nvm_addr_out,
    output logic [DATA_W-1:0] nvm_data_out
);
    dewc_state_e st_ff, nxt_st;
    dewc_lock_e lk_ff, nxt_lk;
    logic write_enable_bit_ff, nxt_write_enable_bit;
    logic err_ff, nxt_err;
    logic done_ff, nxt_done;
    logic wake_ff, nxt_wake;
    logic [AW-1:0] addr_ff, nxt_addr;
    logic [DATA_W-1:0] data_ff, nxt_data;
    logic start;
    logic t_busy;
    logic t_exp;

    initial begin
        if (AW < 1 || AW > 8) begin
            $error("dewc_core: AW must be 1..8");
        end
    end

    // [R10] Unlock gate check
    assign start = sw_in.ctrl_set_wr && write_enable_bit_ff && (lk_ff == DEWC_LK_OPEN)
        && (st_ff == DEWC_IDLE);

    // [R1] Timer free of the sleep input
    dewc_timer #(
        .CYCLES(WRITE_CYC)
    ) u_timer (
        .clk_sys_in(clk_sys_in),
        .rst_in(rst_in),
        .start_in(start),
        .abort_in(brownout_in && st_ff == DEWC_BUSY),
        .busy_out(t_busy),
        .expire_out(t_exp)
    );

    // Unlock tracker: any other access in between, except an error clear, relocks
    always_comb begin
        nxt_lk = lk_ff;
        if (sw_in.unlock_we) begin
            if (sw_in.unlock_val == UNLOCK_KEY1) begin
                nxt_lk = DEWC_LK_K1;
            end else if (sw_in.unlock_val == UNLOCK_KEY2 && lk_ff == DEWC_LK_K1) begin
                nxt_lk = DEWC_LK_OPEN;
            end else begin
                nxt_lk = DEWC_LK_NONE;
            end
        end else if (sw_in.ctrl_set_wr || sw_in.ctrl_write_enable_bit_we || sw_in.flag_we) begin
            nxt_lk = DEWC_LK_NONE;
        end
    end

    // Sequencer, latches, flags and wake
    always_comb begin
        nxt_st = st_ff;
        nxt_write_enable_bit = write_enable_bit_ff;
        nxt_err = err_ff;
        nxt_done = done_ff;
        nxt_addr = addr_ff;
        nxt_data = data_ff;
        if (sw_in.ctrl_write_enable_bit_we) begin
            nxt_write_enable_bit = sw_in.ctrl_write_enable_bit_val;
        end
        if (sw_in.ctrl_err_clr) begin
            nxt_err = 1'b0;
        end
        if (sw_in.flag_we) begin
            nxt_done = sw_in.flag_val;
        end
        unique case (st_ff)
            DEWC_IDLE: begin
                // [R11] Capture address and data
                if (start) begin
                    nxt_st = DEWC_BUSY;
                    nxt_addr = eeprom_address_reg_in;
                    nxt_data = eeprom_data_reg_in;
                end
            end
            DEWC_BUSY: begin
                // [R8] Aborted write flags error
                if (brownout_in) begin
                    nxt_st = DEWC_IDLE;
                    nxt_err = 1'b1;
                end else if (t_exp) begin
                    nxt_st = DEWC_DONE;
                end
            end
            DEWC_DONE: begin
                // [R5] Set beats software update
                nxt_st = DEWC_IDLE;
                nxt_done = 1'b1;
            end
            default: begin
                nxt_st = DEWC_IDLE;
            end
        endcase
        // [R3] Wake gating
        nxt_wake = (done_ff && write_done_irq_enable_in && peripheral_group_enable_in)
            || other_irq_pending_in;
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            st_ff <= DEWC_IDLE;
            lk_ff <= DEWC_LK_NONE;
            write_enable_bit_ff <= 1'b0;
            err_ff <= 1'b0;
            done_ff <= 1'b0;
            wake_ff <= 1'b0;
            addr_ff <= '0;
            data_ff <= RESET_BYTE;
        end else begin
            st_ff <= nxt_st;
            lk_ff <= nxt_lk;
            write_enable_bit_ff <= nxt_write_enable_bit;
            err_ff <= nxt_err;
            done_ff <= nxt_done;
            wake_ff <= nxt_wake;
            addr_ff <= nxt_addr;
            data_ff <= nxt_data;
        end
    end

    // [R4] Initiate bit mirrors busy
    always_comb begin
        eeprom_control_reg_out = RESET_BYTE;
        eeprom_control_reg_out[CTRL_WR_BIT] = (st_ff == DEWC_BUSY);
        eeprom_control_reg_out[CTRL_WRITE_ENABLE_BIT_BIT] = write_enable_bit_ff;
        eeprom_control_reg_out[CTRL_ERR_BIT] = err_ff;
    end

    // [R2] Done flag and wake outputs
    assign write_done_flag_out = done_ff;
    assign write_error_flag_out = err_ff;
    assign write_enable_bit_out = write_enable_bit_ff;
    assign wake_out = wake_ff;
    // [R11] Held address and data to the array
    assign nvm_we_out = (st_ff == DEWC_BUSY);
    assign nvm_addr_out = addr_ff;
    assign nvm_data_out = data_ff;

    // Assertions
    AST_START_GATED: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R10]
        (st_ff != DEWC_BUSY ##1 st_ff == DEWC_BUSY) |-> ($past(sw_in.ctrl_set_wr)
        && $past(write_enable_bit_ff) && $past(lk_ff) == DEWC_LK_OPEN))
        else $error("start gating broken");
    AST_START_NEEDS_KEY: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R10]
        (st_ff == DEWC_IDLE && (lk_ff != DEWC_LK_OPEN || !write_enable_bit_ff)) |=> st_ff != DEWC_BUSY)
        else $error("write started without unlock");
    AST_WR_SET_BUSY: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R4]
        t_busy |-> eeprom_control_reg_out[CTRL_WR_BIT])
        else $error("initiate bit clear during write");
    AST_WR_CLEARS: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R4]
        (st_ff == DEWC_BUSY && t_exp && !brownout_in) |=> !eeprom_control_reg_out[CTRL_WR_BIT])
        else $error("initiate bit did not clear");
    AST_DONE_SET: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R2]
        (st_ff == DEWC_DONE) |=> write_done_flag_out)
        else $error("done flag not set");
    AST_DONE_WINS: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R5]
        (st_ff == DEWC_DONE && sw_in.flag_we && !sw_in.flag_val) |=> write_done_flag_out)
        else $error("done flag lost to software update");
    AST_SLEEP_RUNS: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R1]
        (t_busy && core_asleep_in && !brownout_in) |=> (st_ff == DEWC_BUSY || st_ff == DEWC_DONE))
        else $error("write stalled in sleep");
    AST_WAKE_GATE: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R3]
        (done_ff && write_done_irq_enable_in && peripheral_group_enable_in) |=> wake_out)
        else $error("wake missing");
    AST_NO_WAKE: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R3]
        (!other_irq_pending_in && !(done_ff && write_done_irq_enable_in
        && peripheral_group_enable_in)) |=> !wake_out)
        else $error("spurious wake");
    AST_ADDR_STABLE: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R11]
        (st_ff == DEWC_BUSY && $past(st_ff) == DEWC_BUSY) |-> $stable(nvm_addr_out)
        && $stable(nvm_data_out))
        else $error("address or data moved during write");
    AST_ERR_ABORT: assert property (@(posedge clk_sys_in) disable iff (rst_in) // [R8]
        (st_ff == DEWC_BUSY && brownout_in) |=> write_error_flag_out)
        else $error("error flag not set on abort");

    COV_WRITE: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        st_ff == DEWC_DONE);
    COV_RACE: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        st_ff == DEWC_DONE && sw_in.flag_we);
    COV_WAKE: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        core_asleep_in && $rose(wake_out));
    COV_ABORT: cover property (@(posedge clk_sys_in) disable iff (rst_in)
        st_ff == DEWC_BUSY && brownout_in);
endmodule

// *** shared/dewc_pkg.sv ***
// Package: constants and types for the data EEPROM write control block
package dewc_pkg;
    // Control register bit positions
    localparam int CTRL_RD_BIT = 0;
    localparam int CTRL_WR_BIT = 1;
    localparam int CTRL_WRITE_ENABLE_BIT_BIT = 2;
    localparam int CTRL_ERR_BIT = 3;
    // Unlock sequence bytes
    localparam logic [7:0] UNLOCK_KEY1 = 8'h55;
    localparam logic [7:0] UNLOCK_KEY2 = 8'haa;
    // Self-timed write duration in microseconds and clock rate
    localparam int WRITE_TIME_US = 4000;
    localparam int CLK_MHZ = 100;
    localparam int WRITE_CYCLES = WRITE_TIME_US * CLK_MHZ;
    // Widths and reset values
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic [7:0] RESET_BYTE = 8'h00;

    // Software register write strobes from the core
    typedef struct packed {
        logic ctrl_set_wr;
        logic ctrl_write_enable_bit_we;
        logic ctrl_write_enable_bit_val;
        logic ctrl_err_clr;
        logic unlock_we;
        logic [7:0] unlock_val;
        logic flag_we;
        logic flag_val;
    } dewc_sw_s;

    // Write sequencer states
    typedef enum logic [1:0] {
        DEWC_IDLE = 2'b00,
        DEWC_BUSY = 2'b01,
        DEWC_DONE = 2'b10
    } dewc_state_e;

    // Unlock tracker states
    typedef enum logic [1:0] {
        DEWC_LK_NONE = 2'b00,
        DEWC_LK_K1 = 2'b01,
        DEWC_LK_OPEN = 2'b10
    } dewc_lock_e;
endpackage

// *** rtl/dewc_timer.sv ***
// Self-timed write duration counter
`timescale 1ns/1ps
module dewc_timer
    import dewc_pkg::*;
#(
    parameter int CYCLES = WRITE_CYCLES
) (
    input wire logic clk_sys_in,
    input wire logic rst_in,
    input wire logic start_in,
    input wire logic abort_in,
    output logic busy_out,
    output logic expire_out
);
    localparam int CW = $clog2(CYCLES + 1);
    logic [CW-1:0] cnt_ff;
    logic [CW-1:0] nxt_cnt;
    logic exp_ff;
    logic nxt_exp;

    initial begin
        if (CYCLES < 2) begin
            $error("dewc_timer: CYCLES must be at least 2");
        end
    end

    // Count down from the loaded duration, pulse on reaching zero
    always_comb begin
        nxt_cnt = cnt_ff;
        nxt_exp = 1'b0;
        if (abort_in) begin
            nxt_cnt = '0;
        end else if (start_in) begin
            nxt_cnt = CW'(CYCLES);
        end else if (cnt_ff != '0) begin
            nxt_cnt = cnt_ff - CW'(1);
            nxt_exp = (cnt_ff == CW'(1));
        end
    end

    always_ff @(posedge clk_sys_in) begin
        if (rst_in) begin
            cnt_ff <= '0;
            exp_ff <= 1'b0;
        end else begin
            cnt_ff <= nxt_cnt;
            exp_ff <= nxt_exp;
        end
    end

    assign busy_out = (cnt_ff != '0);
    assign expire_out = exp_ff;
endmodule

// *** tb/dewc_sw_model.sv ***
// Core software model that issues register writes and sleeps during a write
`timescale 1ns/1ps
module dewc_sw_model
    import dewc_pkg::*;
(
    input wire logic clk_sys_in,
    input wire logic [7:0] ctrl_in,
    output dewc_sw_s sw_out,
    output logic asleep_out
);
    logic active_ff;

    // Idle strobes and awake core at time zero
    initial begin
        sw_out = '0;
        asleep_out = 1'b0;
        active_ff = 1'b0;
    end

    // One strobe cycle, launched just after the edge
    task automatic step(input dewc_sw_s s);
        @(posedge clk_sys_in);
        #1 sw_out = s;
    endtask

    // Strobe at once, for a write that must hit the coming edge
    task automatic poke(input dewc_sw_s s);
        sw_out = s;
    endtask

    // Enable, unlock and initiate, then sleep
    task automatic start(input logic [7:0] b1, input logic [7:0] b2, input logic write_enable_bit);
        step('{ctrl_write_enable_bit_we: 1'b1, ctrl_write_enable_bit_val: write_enable_bit, default: '0});
        step('{unlock_we: 1'b1, unlock_val: b1, default: '0});
        step('{unlock_we: 1'b1, unlock_val: b2, default: '0});
        step('{ctrl_set_wr: 1'b1, default: '0});
        step('0);
        active_ff = 1'b1;
        asleep_out = 1'b1;
    endtask

    // bounded wait, then judge by initiate and error bits
    task automatic wait_done(input int limit, output logic ok);
        int n;
        n = 0;
        while (active_ff && ctrl_in[CTRL_WR_BIT] !== 1'b0 && n < limit) begin
            @(posedge clk_sys_in);
            #1 n++;
        end
        ok = (n < limit) && (ctrl_in[CTRL_ERR_BIT] === 1'b0);
        active_ff = 1'b0;
        asleep_out = 1'b0;
    endtask
endmodule

// *** tb/data_eeprom_write_control_tb.sv ***
// Testbench for the data EEPROM write control block
`timescale 1ns/1ps
module data_eeprom_write_control_tb;
    import dewc_pkg::*;
    localparam int WC = 20;
    logic clk_sys_in = 1'b0;
    logic rst_in = 1'b1;
    dewc_sw_s sw;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] data = '0;
    logic wde = 1'b0;
    logic pge = 1'b0;
    logic other = 1'b0;
    logic bro = 1'b0;
    logic asleep;
    logic [7:0] ctrl;
    logic done, err, wen, wake, we, ok;
    logic we_q = 1'b0;
    logic [ADDR_W-1:0] nvm_a;
    logic [DATA_W-1:0] nvm_d;
    logic [14:0] exp_q[$];
    int n_mismatch = 0;
    int tests_run = 0;
    logic [7:0] k1 [3] = '{8'h55, 8'haa, 8'h55};
    logic [7:0] k2 [3] = '{8'h55, 8'h55, 8'haa};
    logic wr [3] = '{1'b1, 1'b1, 1'b0};

    always #5 clk_sys_in = ~clk_sys_in;

    dewc_sw_model u_sw (.clk_sys_in(clk_sys_in), .ctrl_in(ctrl), .sw_out(sw),
        .asleep_out(asleep));

    dewc_core #(.WRITE_CYC(WC)) dut (.clk_sys_in(clk_sys_in), .rst_in(rst_in), .sw_in(sw),
        .eeprom_address_reg_in(addr), .eeprom_data_reg_in(data),
        .write_done_irq_enable_in(wde), .peripheral_group_enable_in(pge),
        .other_irq_pending_in(other), .core_asleep_in(asleep), .brownout_in(bro),
        .eeprom_control_reg_out(ctrl), .write_done_flag_out(done),
        .write_error_flag_out(err), .write_enable_bit_out(wen), .wake_out(wake),
        .nvm_we_out(we), .nvm_addr_out(nvm_a), .nvm_data_out(nvm_d));

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic end_sim();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_sys_in);
        #1;
    endtask

    // Random target; a good sequence notes the write at its start and end
    task automatic go(input logic [7:0] a, input logic [7:0] b, input logic w);
        addr = ADDR_W'($urandom);
        data = DATA_W'($urandom);
        if (a == UNLOCK_KEY1 && b == UNLOCK_KEY2 && w) begin
            exp_q.push_back({addr, data});
            exp_q.push_back({addr, data});
        end
        u_sw.start(a, b, w);
    endtask

    task automatic clr_flag();
        u_sw.step('{flag_we: 1'b1, default: '0});
        u_sw.step('0);
        tick(1);
    endtask

    // Memory port watcher: each write edge takes the oldest note
    always @(posedge clk_sys_in) begin
        we_q <= we;
        if (we !== we_q) begin
            if (exp_q.size() == 0) begin
                check(32'h0, 32'h1);
            end else begin
                check({nvm_a, nvm_d}, exp_q.pop_front());
            end
        end
    end

    // Hang guard
    initial begin
        repeat (20000) @(posedge clk_sys_in);
        n_mismatch++;
        end_sim();
    end

    // Main sequence
    initial begin
        void'($urandom(39));
        tick(2);
        rst_in = 1'b0;
        wde = 1'b1;
        pge = 1'b1;
        go(UNLOCK_KEY1, UNLOCK_KEY2, 1'b1);
        check({ctrl[CTRL_WR_BIT], we}, 2'b11);
        u_sw.wait_done(WC + 8, ok);
        check(ok, 1'b1);
        tick(2);
        check({done, wake}, 2'b11);
        clr_flag();
        check({done, wake}, 2'b00);
        $display("test 1 done");
        wde = 1'b0;
        go(UNLOCK_KEY1, UNLOCK_KEY2, 1'b1);
        u_sw.wait_done(WC + 8, ok);
        tick(3);
        check({done, wake}, 2'b10);
        other = 1'b1;
        tick(2);
        check(wake, 1'b1);
        other = 1'b0;
        clr_flag();
        $display("test 2 done");
        for (int i = 0; i < 3; i++) begin
            go(k1[i], k2[i], wr[i]);
            check({ctrl[CTRL_WR_BIT], we}, 2'b00);
            u_sw.wait_done(2, ok);
        end
        check({wen, ctrl[CTRL_WRITE_ENABLE_BIT_BIT]}, 2'b00);
        $display("test 3 done");
        wde = 1'b1;
        go(UNLOCK_KEY1, UNLOCK_KEY2, 1'b1);
        u_sw.wait_done(WC + 8, ok);
        u_sw.poke('{flag_we: 1'b1, default: '0});
        u_sw.step('0);
        check(done, 1'b1);
        clr_flag();
        $display("test 4 done");
        go(UNLOCK_KEY1, UNLOCK_KEY2, 1'b1);
        tick(3);
        bro = 1'b1;
        tick(1);
        bro = 1'b0;
        u_sw.wait_done(WC + 8, ok);
        check({ok, err, ctrl[CTRL_ERR_BIT]}, 3'b011);
        u_sw.step('{ctrl_err_clr: 1'b1, default: '0});
        u_sw.step('0);
        check(err, 1'b0);
        $display("test 5 done");
        tick(2);
        check(exp_q.size(), 32'h0);
        end_sim();
    end
endmodule
